/* src/lane_init_polarity_connecting.sv */
// Lane initialisation: started, rx-inverted and connecting states with receive word handling
// Notes on behaviour
// - Started moves to rx-inverted after three inverted first training words, no errors.
// - Started moves to rx-inverted after three inverted second training words, no errors.
// - Rx-inverted keeps transmitter, its PLL, receiver and clock recovery enabled.
// - Rx-inverted inverts every received bit before word decoding.
// - Rx-inverted and connecting both accept and decode lane control words.
// - Simultaneous exits follow fixed priority: resets first, shutdown words last.
// - Hard reset request goes to cold reset, above everything else.
// - Soft reset request goes to line clear unless hard reset present.
// - No signal at receiver goes to line clear from rx-inverted or connecting, below both resets.
// - 1023 first or second training words without errors enter connecting.
// - Any receive error word restarts every training word count.
// - Initialisation timeout expiry goes to line clear.
// - Eight consecutive signal-gone words, or eight consecutive standby words, go to line clear, lowest.
// - Connecting keeps front end enabled and sends second training words.
// - Connecting moves to connected after three second training words, no errors.
// - Connecting moves to connected after three matching parameter training words.
// - Entering started starts a 2 ms initialisation timeout timer.
// - Started sends first training words for the far end to count.
`timescale 1ns/1ps
module lane_init_polarity_connecting #(
  parameter int unsigned TimeoutCycles = lane_init_pkg::INIT_TIMEOUT_CYCLES,
  parameter int unsigned TrainTotal = lane_init_pkg::TRAIN_TOTAL
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Requests from management and neighbouring states
  input wire logic startedEnter,
  input wire logic hardResetReq,
  input wire logic softResetReq,
  // Serial receive pins, link clock domain
  input wire logic rxLinkClk,
  input wire logic rxSerial,
  input wire logic noSignal,
  // Front end control and transmit word
  output lane_init_pkg::front_ctrl_t frontCtrl,
  output logic [31:0] txWord,
  // State and hand-over
  output lane_init_pkg::lane_state_t laneState,
  output lane_init_pkg::exit_pulse_t exitPulse,
  output logic timeoutExpired,
  output logic [7:0] connectParams
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic linkClkS;
  logic serialS;
  logic noSignalS;
  logic linkClkPrevQ;
  logic linkRise;

  sync_two_flop uSyncClk (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(rxLinkClk),
    .syncOut(linkClkS)
  );

  sync_two_flop uSyncData (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(rxSerial),
    .syncOut(serialS)
  );

  sync_two_flop uSyncNoSig (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(noSignal),
    .syncOut(noSignalS)
  );

  // Edge finder on the synchronised link clock
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      linkClkPrevQ <= 1'b0;
    else
      linkClkPrevQ <= linkClkS;
  end

  assign linkRise = linkClkS && !linkClkPrevQ;

  ////////////////////////////////////////////////////////////////////////////
  // Deserialiser with marker alignment

  lane_init_pkg::lane_state_t stateQ;
  lane_init_pkg::lane_state_t stateD;
  logic [31:0] shiftQ;
  logic [31:0] shiftD;
  logic [4:0] bitCntQ;
  logic alignedQ;
  logic wordValidQ;
  logic [31:0] wordQ;
  logic inBit;
  logic active;

  assign active = (stateQ != lane_init_pkg::ST_IDLE);
  // Inversion sits ahead of the shifter so the decoder sees corrected bits
  assign inBit = frontCtrl.rxInvert ? ~serialS : serialS;
  assign shiftD = {shiftQ[30:0], inBit};

  // Word boundary found on a marker or inverted marker, then every 32 bits
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !active)
    begin
      shiftQ <= '0;
      bitCntQ <= '0;
      alignedQ <= 1'b0;
      wordValidQ <= 1'b0;
      wordQ <= '0;
    end
    else
    begin
      wordValidQ <= 1'b0;
      if (linkRise)
      begin
        shiftQ <= shiftD;
        bitCntQ <= bitCntQ + 1'b1;
        if (!alignedQ)
        begin
          // Inverted markers also align, so polarity detection can see them
          if (shiftD[31:24] == lane_init_pkg::WORD_MARKER || shiftD[31:24] == ~lane_init_pkg::WORD_MARKER)
          begin
            alignedQ <= 1'b1;
            bitCntQ <= '0;
            wordValidQ <= 1'b1;
            wordQ <= shiftD;
          end
        end
        else if (bitCntQ == 5'h1f)
        begin
          wordValidQ <= 1'b1;
          wordQ <= shiftD;
          // A word with no marker means alignment was lost
          alignedQ <= (shiftD[31:24] == lane_init_pkg::WORD_MARKER) || (shiftD[31:24] == ~lane_init_pkg::WORD_MARKER);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word decoder

  lane_init_pkg::rx_class_t rxC;
  logic [31:0] invWord;
  logic plainMark;
  logic invMark;

  assign invWord = ~wordQ;
  assign plainMark = wordValidQ && frontCtrl.ctrlWordEnable && wordQ[31:24] == lane_init_pkg::WORD_MARKER;
  assign invMark = wordValidQ && frontCtrl.ctrlWordEnable && invWord[31:24] == lane_init_pkg::WORD_MARKER;

  // Control words decoded in every state this block owns
  always_comb
  begin
    rxC.valid = wordValidQ;
    rxC.firstTrain = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_FIRST_TRAIN;
    rxC.secondTrain = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_SECOND_TRAIN;
    rxC.paramTrain = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_PARAM_TRAIN;
    rxC.rxError = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_RX_ERROR;
    rxC.signalGone = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_SIGNAL_GONE;
    rxC.standby = plainMark && wordQ[23:16] == lane_init_pkg::TYPE_STANDBY;
    rxC.invFirst = invMark && invWord[23:16] == lane_init_pkg::TYPE_FIRST_TRAIN;
    rxC.invSecond = invMark && invWord[23:16] == lane_init_pkg::TYPE_SECOND_TRAIN;
    rxC.params = wordQ[15:8];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run counters

  logic stateChange;
  logic cntClr;
  logic hitInvFirst;
  logic hitInvSecond;
  logic hitTotal;
  logic hitSecond;
  logic hitParam;
  logic hitGone;
  logic hitStandby;
  logic paramsMatch;
  logic [7:0] lastParamsQ;

  assign stateChange = (stateD != stateQ);
  // Errors restart every training count; counts also restart on a state change
  assign cntClr = stateChange || rxC.rxError;
  assign paramsMatch = (rxC.params == lastParamsQ);

  run_counter #(.W(2), .MAX(2'(lane_init_pkg::INVERT_RUN))) uCntInvFirst (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cntClr),
    .restart(1'b0),
    .inc(rxC.invFirst),
    .hit(hitInvFirst)
  );

  run_counter #(.W(2), .MAX(2'(lane_init_pkg::INVERT_RUN))) uCntInvSecond (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cntClr),
    .restart(1'b0),
    .inc(rxC.invSecond),
    .hit(hitInvSecond)
  );

  // Any mix of first and second training words adds to the total
  run_counter #(.W(10), .MAX(10'(TrainTotal))) uCntTotal (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cntClr),
    .restart(1'b0),
    .inc(rxC.firstTrain || rxC.secondTrain),
    .hit(hitTotal)
  );

  run_counter #(.W(2), .MAX(2'(lane_init_pkg::CONNECT_RUN))) uCntSecond (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cntClr),
    .restart(1'b0),
    .inc(rxC.secondTrain),
    .hit(hitSecond)
  );

  // A parameter change restarts the run at one, counting the new word
  run_counter #(.W(2), .MAX(2'(lane_init_pkg::CONNECT_RUN))) uCntParam (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(cntClr),
    .restart(rxC.paramTrain && !paramsMatch),
    .inc(rxC.paramTrain),
    .hit(hitParam)
  );

  // Consecutive runs break on any other decoded word
  run_counter #(.W(4), .MAX(4'(lane_init_pkg::SHUTDOWN_RUN))) uCntGone (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(stateChange || (rxC.valid && !rxC.signalGone)),
    .restart(1'b0),
    .inc(rxC.signalGone),
    .hit(hitGone)
  );

  run_counter #(.W(4), .MAX(4'(lane_init_pkg::SHUTDOWN_RUN))) uCntStandby (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clr(stateChange || (rxC.valid && !rxC.standby)),
    .restart(1'b0),
    .inc(rxC.standby),
    .hit(hitStandby)
  );

  // Last parameter value seen, compared by the next parameter word
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      lastParamsQ <= '0;
    else if (rxC.paramTrain)
      lastParamsQ <= rxC.params;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Initialisation timeout timer

  logic [31:0] timerQ;
  logic timerRunQ;

  // Started on entry to started only; never restarted by later states
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      timerQ <= '0;
      timerRunQ <= 1'b0;
    end
    else if (stateQ == lane_init_pkg::ST_IDLE && startedEnter)
    begin
      timerQ <= '0;
      timerRunQ <= 1'b1;
    end
    else if (stateD == lane_init_pkg::ST_IDLE)
      timerRunQ <= 1'b0;
    else if (timerRunQ && timerQ != TimeoutCycles)
      timerQ <= timerQ + 32'h00000001;
  end

  assign timeoutExpired = timerRunQ && (timerQ == TimeoutCycles);

  ////////////////////////////////////////////////////////////////////////////
  // State machine

  logic shutdownSeen;
  lane_init_pkg::exit_pulse_t exitD;

  assign shutdownSeen = hitGone || hitStandby;

  // Exits checked in priority order, resets first and shutdown words last
  always_comb
  begin
    stateD = stateQ;
    exitD = '0;
    unique case (stateQ)
      lane_init_pkg::ST_IDLE:
      begin
        if (startedEnter)
          stateD = lane_init_pkg::ST_STARTED;
      end
      lane_init_pkg::ST_STARTED:
      begin
        if (hardResetReq)
          exitD.toHardReset = 1'b1;
        else if (softResetReq)
          exitD.toLineClear = 1'b1;
        else if (hitTotal)
          stateD = lane_init_pkg::ST_CONNECTING;
        else if (hitInvFirst || hitInvSecond)
          stateD = lane_init_pkg::ST_RX_INVERTED;
        else if (timeoutExpired)
          exitD.toLineClear = 1'b1;
        else if (shutdownSeen)
          exitD.toLineClear = 1'b1;
      end
      lane_init_pkg::ST_RX_INVERTED:
      begin
        if (hardResetReq)
          exitD.toHardReset = 1'b1;
        else if (softResetReq)
          exitD.toLineClear = 1'b1;
        else if (noSignalS)
          exitD.toLineClear = 1'b1;
        else if (hitTotal)
          stateD = lane_init_pkg::ST_CONNECTING;
        else if (timeoutExpired)
          exitD.toLineClear = 1'b1;
        else if (shutdownSeen)
          exitD.toLineClear = 1'b1;
      end
      lane_init_pkg::ST_CONNECTING:
      begin
        if (hardResetReq)
          exitD.toHardReset = 1'b1;
        else if (softResetReq)
          exitD.toLineClear = 1'b1;
        else if (noSignalS)
          exitD.toLineClear = 1'b1;
        else if (hitSecond)
          exitD.toConnected = 1'b1;
        else if (hitParam)
          exitD.toConnected = 1'b1;
        else if (timeoutExpired)
          exitD.toLineClear = 1'b1;
        else if (shutdownSeen)
          exitD.toLineClear = 1'b1;
      end
    endcase
    if (exitD != '0)
      stateD = lane_init_pkg::ST_IDLE;
  end

  // State and hand-over pulses, one flop each
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      stateQ <= lane_init_pkg::ST_IDLE;
      exitPulse <= '0;
    end
    else
    begin
      stateQ <= stateD;
      exitPulse <= exitD;
    end
  end

  // Parameters captured whenever connected is reached, by second training or parameter words
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      connectParams <= '0;
    else if (exitD.toConnected)
      connectParams <= lastParamsQ;
  end

  assign laneState = stateQ;

  ////////////////////////////////////////////////////////////////////////////
  // Front end enables and transmit word

  // Registered so the front end sees glitch-free controls
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      frontCtrl <= '0;
      txWord <= lane_init_pkg::WORD_IDLE;
    end
    else
    begin
      frontCtrl.txEnable <= (stateD != lane_init_pkg::ST_IDLE);
      frontCtrl.txPllEnable <= (stateD != lane_init_pkg::ST_IDLE);
      frontCtrl.rxEnable <= (stateD != lane_init_pkg::ST_IDLE);
      frontCtrl.rxCdrEnable <= (stateD != lane_init_pkg::ST_IDLE);
      // Inversion stays on into connecting, since the far end is still crossed
      frontCtrl.rxInvert <= (stateD == lane_init_pkg::ST_RX_INVERTED) ||
        (stateD == lane_init_pkg::ST_CONNECTING && frontCtrl.rxInvert);
      frontCtrl.ctrlWordEnable <= (stateD != lane_init_pkg::ST_IDLE);
      unique case (stateD)
        lane_init_pkg::ST_STARTED: txWord <= lane_init_pkg::WORD_FIRST_TRAIN;
        lane_init_pkg::ST_RX_INVERTED: txWord <= lane_init_pkg::WORD_FIRST_TRAIN;
        lane_init_pkg::ST_CONNECTING: txWord <= lane_init_pkg::WORD_SECOND_TRAIN;
        lane_init_pkg::ST_IDLE: txWord <= lane_init_pkg::WORD_IDLE;
      endcase
    end
  end

endmodule

/* src/lane_init_pkg.sv */
// Shared constants and types for the lane initialisation polarity and connecting block
package lane_init_pkg;

  // Clock and timeout timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned INIT_TIMEOUT_NS = 2000000;
  localparam int unsigned INIT_TIMEOUT_CYCLES = INIT_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 32;

  // Word format: [31:24] marker, [23:16] type, [15:8] parameters, [7:0] spare
  localparam int unsigned WORD_W = 32;
  localparam int unsigned MARK_LSB = 24;
  localparam int unsigned TYPE_LSB = 16;
  localparam int unsigned PARAM_LSB = 8;
  localparam logic [7:0] WORD_MARKER = 8'hbc;
  localparam logic [7:0] TYPE_FIRST_TRAIN = 8'h01;
  localparam logic [7:0] TYPE_SECOND_TRAIN = 8'h02;
  localparam logic [7:0] TYPE_PARAM_TRAIN = 8'h03;
  localparam logic [7:0] TYPE_RX_ERROR = 8'h04;
  localparam logic [7:0] TYPE_SIGNAL_GONE = 8'h05;
  localparam logic [7:0] TYPE_STANDBY = 8'h06;
  localparam logic [31:0] WORD_FIRST_TRAIN = 32'hbc010000;
  localparam logic [31:0] WORD_SECOND_TRAIN = 32'hbc020000;
  localparam logic [31:0] WORD_IDLE = 32'h00000000;

  // Run lengths
  localparam int unsigned INVERT_RUN = 3;
  localparam int unsigned TRAIN_TOTAL = 1023;
  localparam int unsigned CONNECT_RUN = 3;
  localparam int unsigned SHUTDOWN_RUN = 8;
  localparam int unsigned BITCNT_W = 5;

  // Machine states owned by this block; idle means a neighbouring state holds the lane
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STARTED,
    ST_RX_INVERTED,
    ST_CONNECTING
  } lane_state_t;

  // Enables driven towards the serial front end
  typedef struct packed {
    logic txEnable;
    logic txPllEnable;
    logic rxEnable;
    logic rxCdrEnable;
    logic rxInvert;
    logic ctrlWordEnable;
  } front_ctrl_t;

  // One-cycle hand-over pulses to the neighbouring states
  typedef struct packed {
    logic toHardReset;
    logic toLineClear;
    logic toConnected;
  } exit_pulse_t;

  // Decoded receive word classes
  typedef struct packed {
    logic valid;
    logic firstTrain;
    logic secondTrain;
    logic paramTrain;
    logic rxError;
    logic signalGone;
    logic standby;
    logic invFirst;
    logic invSecond;
    logic [7:0] params;
  } rx_class_t;

endpackage

/* src/sync_two_flop.sv */
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module sync_two_flop (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Level in and out
  input wire logic asyncIn,
  output logic syncOut
);

  logic metaQ;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      metaQ <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      metaQ <= asyncIn;
      syncOut <= metaQ;
    end
  end

endmodule

/* src/run_counter.sv */
// Saturating run counter with clear, restart and increment
`timescale 1ns/1ps
module run_counter #(
  parameter int unsigned W = 4,
  parameter logic [W-1:0] MAX = '1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic clr,
  input wire logic restart,
  input wire logic inc,
  // Status
  output logic hit
);

  logic [W-1:0] countQ;

  // Clear wins, restart loads one, saturate at the target
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || clr)
      countQ <= '0;
    else if (restart)
      countQ <= {{(W-1){1'b0}}, 1'b1};
    else if (inc && countQ != MAX)
      countQ <= countQ + 1'b1;
  end

  assign hit = (countQ == MAX);

endmodule

/* sim/lane_init_props.sv */
// Concurrent checks on the lane initialisation block's ports
`timescale 1ns/1ps
module lane_init_props #(
  parameter int unsigned TimeoutCycles = 2000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Requests
  input wire logic hardResetReq,
  input wire logic softResetReq,
  input wire logic noSignal,
  // Block outputs
  input wire lane_init_pkg::front_ctrl_t frontCtrl,
  input wire logic [31:0] txWord,
  input wire lane_init_pkg::lane_state_t laneState,
  input wire lane_init_pkg::exit_pulse_t exitPulse,
  input wire logic timeoutExpired
);
  logic busy;
  logic inInv;
  logic inConn;
  logic [31:0] tmrCnt_q;

  // State decodes shared by the checks
  assign busy = laneState != lane_init_pkg::ST_IDLE;
  assign inInv = laneState == lane_init_pkg::ST_RX_INVERTED;
  assign inConn = laneState == lane_init_pkg::ST_CONNECTING;

  // Cycles outside idle; a timer restarted mid-run would stretch this past one timeout
  always_ff @(posedge sys_clk)
  begin
    if (!resetn || !busy)
      tmrCnt_q <= 32'h0;
    else
      tmrCnt_q <= tmrCnt_q + 32'h1;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  hard_first_a: assert property (busy && hardResetReq |=> exitPulse == 3'b100)
    else $error("hard reset request not taken first");
  soft_reset_a: assert property (busy && softResetReq && !hardResetReq |=> exitPulse == 3'b010)
    else $error("soft reset request did not clear the line");
  no_signal_a: assert property (not (((inInv || inConn) && noSignal && !hardResetReq && !softResetReq) [*5]))
    else $error("loss of signal ignored");
  inv_front_a: assert property (inInv |-> frontCtrl == 6'h3f)
    else $error("rx-inverted front end settings wrong");
  conn_front_a: assert property (inConn |-> txWord == lane_init_pkg::WORD_SECOND_TRAIN
    && frontCtrl[5:2] == 4'hf && frontCtrl.ctrlWordEnable)
    else $error("connecting front end or word wrong");
  started_word_a: assert property (laneState == lane_init_pkg::ST_STARTED
    |-> txWord == lane_init_pkg::WORD_FIRST_TRAIN)
    else $error("started state sends wrong word");
  conn_source_a: assert property (exitPulse.toConnected |-> $past(inConn) && !busy)
    else $error("connected hand-over from wrong state");
  pulse_once_a: assert property (exitPulse != 3'b000 |-> !busy ##1 exitPulse == 3'b000)
    else $error("exit pulse longer than one cycle");
  timer_bound_a: assert property (busy |-> tmrCnt_q <= TimeoutCycles + 4)
    else $error("run outlasted one timeout");
  early_expiry_a: assert property (busy && tmrCnt_q + 4 < TimeoutCycles |-> !timeoutExpired)
    else $error("timeout flagged early");

  // Main scenarios reached
  cover property (inInv);
  cover property (exitPulse.toConnected);
  cover property (exitPulse.toHardReset);
endmodule

bind lane_init_polarity_connecting lane_init_props #(.TimeoutCycles(TimeoutCycles)) i_lane_init_props (
  .sys_clk(sys_clk), .resetn(resetn), .hardResetReq(hardResetReq), .softResetReq(softResetReq),
  .noSignal(noSignal), .frontCtrl(frontCtrl), .txWord(txWord), .laneState(laneState),
  .exitPulse(exitPulse), .timeoutExpired(timeoutExpired)
);

/* sim/peer_lane_model.sv */
// Far-end lane transmitter driving the serial receive pins
`timescale 1ns/1ps
module peer_lane_model (
  // Serial pins towards the block
  output logic rxLinkClk,
  output logic rxSerial
);
  // Link clock stands still low outside frames
  initial
  begin
    rxLinkClk = 1'b0;
    rxSerial = 1'b1;
  end

  // One word MSB first, 160 ns a bit; swapped models a crossed pair at the far end
  task automatic send_word(input logic [31:0] w, input logic swapped);
    logic [31:0] s;
    s = swapped ? ~w : w;
    #7;
    for (int i = 31; i >= 0; i--)
    begin
      rxSerial = s[i];
      #80;
      rxLinkClk = 1'b1;
      #80;
      rxLinkClk = 1'b0;
    end
    // Released line shows the inverse of the last bit, never a stale copy
    rxSerial = ~s[0];
  endtask
endmodule

/* sim/testbench.sv */
// Self-checking bench for the lane polarity and connecting block
`timescale 1ns/1ps
module testbench;
  // Timeout long enough for the training run; training total cut to keep the run short
  localparam int unsigned TimeoutSim = 10000;
  localparam int unsigned TrainTotalSim = 16;
  localparam int CycleCeiling = 40000;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic startedEnter = 1'b0;
  logic hardResetReq = 1'b0;
  logic softResetReq = 1'b0;
  logic noSignal = 1'b0;
  logic rxLinkClk;
  logic rxSerial;
  lane_init_pkg::front_ctrl_t frontCtrl;
  logic [31:0] txWord;
  lane_init_pkg::lane_state_t laneState;
  lane_init_pkg::exit_pulse_t exitPulse;
  logic timeoutExpired;
  logic [7:0] connectParams;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;

  always #10 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////////
  lane_init_polarity_connecting #(.TimeoutCycles(TimeoutSim), .TrainTotal(TrainTotalSim)) i_lane_init_polarity_connecting (
    .sys_clk(sys_clk), .resetn(resetn), .startedEnter(startedEnter), .hardResetReq(hardResetReq),
    .softResetReq(softResetReq), .rxLinkClk(rxLinkClk), .rxSerial(rxSerial), .noSignal(noSignal),
    .frontCtrl(frontCtrl), .txWord(txWord), .laneState(laneState), .exitPulse(exitPulse),
    .timeoutExpired(timeoutExpired), .connectParams(connectParams));
  peer_lane_model i_peer_lane_model (.rxLinkClk(rxLinkClk), .rxSerial(rxSerial));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Peer with crossed pair unless sw is low
  task automatic tx(input logic [7:0] t, input logic [7:0] p = 8'h00, input logic sw = 1'b1);
    i_peer_lane_model.send_word({lane_init_pkg::WORD_MARKER, t, p, 8'h00}, sw);
  endtask

  task automatic start_lane();
    @(posedge sys_clk);
    startedEnter <= 1'b1;
    @(posedge sys_clk);
    startedEnter <= 1'b0;
    @(negedge sys_clk);
    check("started", 32'(laneState), 32'(lane_init_pkg::ST_STARTED));
    check("started word", txWord, lane_init_pkg::WORD_FIRST_TRAIN);
  endtask

  // Bounded wait: decode and hand-over take a handful of cycles
  task automatic wait_state(input string name, input lane_init_pkg::lane_state_t exp);
    for (int n = 0; n < 60 && laneState !== exp; n++)
      @(negedge sys_clk);
    check(name, 32'(laneState), 32'(exp));
  endtask

  task automatic expect_exit(input string name, input logic [2:0] exp, input int maxc);
    for (int n = 0; n < maxc && exitPulse === 3'b000; n++)
      @(negedge sys_clk);
    check(name, {29'h0, exitPulse}, {29'h0, exp});
    check("idle after exit", 32'(laneState), 32'(lane_init_pkg::ST_IDLE));
    @(posedge sys_clk);
    hardResetReq <= 1'b0;
    softResetReq <= 1'b0;
    noSignal <= 1'b0;
    @(posedge sys_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Receive error between inverted first words, then both resets at once
  task automatic test_invert_first();
    start_lane();
    repeat (2) tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    tx(lane_init_pkg::TYPE_RX_ERROR, 8'h00, 1'b0);
    repeat (2) tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    repeat (20) @(negedge sys_clk);
    check("error restart", 32'(laneState), 32'(lane_init_pkg::ST_STARTED));
    tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    wait_state("inverted", lane_init_pkg::ST_RX_INVERTED);
    check("inverted front", {26'h0, frontCtrl}, 32'h3f);
    @(posedge sys_clk);
    hardResetReq <= 1'b1;
    softResetReq <= 1'b1;
    expect_exit("hard over soft", 3'b100, 8);
    $display("test_invert_first done");
  endtask

  task automatic test_invert_second();
    start_lane();
    @(posedge sys_clk);
    softResetReq <= 1'b1;
    expect_exit("soft reset", 3'b010, 8);
    start_lane();
    repeat (3) tx(lane_init_pkg::TYPE_SECOND_TRAIN);
    wait_state("inverted by second", lane_init_pkg::ST_RX_INVERTED);
    @(posedge sys_clk);
    noSignal <= 1'b1;
    expect_exit("no signal", 3'b010, 8);
    $display("test_invert_second done");
  endtask

  // Seven standby then seven gone words, then an eighth gone word
  task automatic test_shutdown();
    start_lane();
    repeat (3) tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    wait_state("inverted again", lane_init_pkg::ST_RX_INVERTED);
    repeat (7) tx(lane_init_pkg::TYPE_STANDBY);
    repeat (7) tx(lane_init_pkg::TYPE_SIGNAL_GONE);
    repeat (20) @(negedge sys_clk);
    check("seven each", 32'(laneState), 32'(lane_init_pkg::ST_RX_INVERTED));
    tx(lane_init_pkg::TYPE_SIGNAL_GONE);
    expect_exit("eight gone", 3'b010, 60);
    $display("test_shutdown done");
  endtask

  task automatic test_connect();
    start_lane();
    repeat (3) tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    wait_state("inverted for run", lane_init_pkg::ST_RX_INVERTED);
    for (int i = 0; i < TrainTotalSim - 1; i++)
      tx(i[0] ? lane_init_pkg::TYPE_SECOND_TRAIN : lane_init_pkg::TYPE_FIRST_TRAIN);
    repeat (20) @(negedge sys_clk);
    check("one short", 32'(laneState), 32'(lane_init_pkg::ST_RX_INVERTED));
    tx(lane_init_pkg::TYPE_SECOND_TRAIN);
    wait_state("connecting", lane_init_pkg::ST_CONNECTING);
    check("second word", txWord, lane_init_pkg::WORD_SECOND_TRAIN);
    check("conn front", {26'h0, frontCtrl}, 32'h3f);
    tx(lane_init_pkg::TYPE_PARAM_TRAIN, 8'h05);
    repeat (2) tx(lane_init_pkg::TYPE_PARAM_TRAIN, 8'h02);
    repeat (2) tx(lane_init_pkg::TYPE_SECOND_TRAIN);
    tx(lane_init_pkg::TYPE_RX_ERROR);
    repeat (2) tx(lane_init_pkg::TYPE_SECOND_TRAIN);
    repeat (20) @(negedge sys_clk);
    check("still connecting", 32'(laneState), 32'(lane_init_pkg::ST_CONNECTING));
    tx(lane_init_pkg::TYPE_SECOND_TRAIN);
    expect_exit("connected", 3'b001, 60);
    check("last params", {24'h0, connectParams}, 32'h02);
    // Plain peer: connecting straight from started, left by parameter words
    start_lane();
    for (int i = 0; i < TrainTotalSim; i++)
      tx(lane_init_pkg::TYPE_FIRST_TRAIN, 8'h00, 1'b0);
    wait_state("connecting plain", lane_init_pkg::ST_CONNECTING);
    check("plain front", {26'h0, frontCtrl}, 32'h3d);
    repeat (3) tx(lane_init_pkg::TYPE_PARAM_TRAIN, 8'h07, 1'b0);
    expect_exit("connected by params", 3'b001, 60);
    check("params kept", {24'h0, connectParams}, 32'h07);
    $display("test_connect done");
  endtask

  // Expiry counted from the start, not from entering rx-inverted
  task automatic test_timeout();
    int t0;
    start_lane();
    t0 = cycles;
    repeat (3) tx(lane_init_pkg::TYPE_FIRST_TRAIN);
    wait_state("inverted pre timeout", lane_init_pkg::ST_RX_INVERTED);
    for (int n = 0; n < TimeoutSim + 50 && exitPulse === 3'b000; n++)
      @(negedge sys_clk);
    check("one timeout", {31'h0, (cycles - t0 + 4 >= TimeoutSim) && (cycles - t0 <= TimeoutSim + 4)}, 32'h1);
    expect_exit("timeout exit", 3'b010, 4);
    $display("test_timeout done");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    test_invert_first();
    test_invert_second();
    test_shutdown();
    test_connect();
    test_timeout();
    wrap_up();
  end

  // Hang guard sized at four timeouts, above the whole bench run
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == CycleCeiling)
    begin
      failures = failures + 1;
      $display("cycle limit reached");
      wrap_up();
    end
  end
endmodule
